/* File: ccs_pkg.sv */
// Package for the channel drive-level register bank (channels d2 to h1).
// Assumes a byte-wide register port with one-cycle strobes.
package ccs_pkg;

  localparam int          CCS_NUM_CH     = 12;
  localparam int          CCS_CODE_W     = 6;
  localparam int          CCS_ADDR_W     = 8;
  localparam int          CCS_DATA_W     = 8;
  localparam int          CCS_IDX_W      = 4;
  localparam logic [7:0]  CCS_OFS_D2     = 8'h5b;
  localparam logic [7:0]  CCS_OFS_E0     = 8'h5c;
  localparam logic [7:0]  CCS_OFS_E1     = 8'h5d;
  localparam logic [7:0]  CCS_OFS_E2     = 8'h5e;
  localparam logic [7:0]  CCS_OFS_F0     = 8'h5f;
  localparam logic [7:0]  CCS_OFS_F1     = 8'h60;
  localparam logic [7:0]  CCS_OFS_F2     = 8'h61;
  localparam logic [7:0]  CCS_OFS_G0     = 8'h62;
  localparam logic [7:0]  CCS_OFS_G1     = 8'h63;
  localparam logic [7:0]  CCS_OFS_G2     = 8'h64;
  localparam logic [7:0]  CCS_OFS_H0     = 8'h65;
  localparam logic [7:0]  CCS_OFS_H1     = 8'h66;
  localparam logic [7:0]  CCS_OFS_FIRST  = CCS_OFS_D2;
  localparam logic [7:0]  CCS_OFS_LAST   = CCS_OFS_H1;
  localparam int          CCS_CODE_LSB   = 0;
  localparam int          CCS_CODE_MSB   = 5;
  localparam logic [1:0]  CCS_RSVD_VAL   = 2'h0;
  localparam logic [7:0]  CCS_UNMAP_VAL  = 8'h00;
  localparam logic [5:0]  CCS_CODE_RST   = 6'h00;
  localparam logic [3:0]  CCS_IDX_RST    = 4'h0;

  typedef struct packed {
    logic [CCS_ADDR_W-1:0] addr;
    logic [CCS_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } ccs_req_t;

  typedef enum logic [1:0] {
    CCS_ST_IDLE = 2'b00,
    CCS_ST_LOAD = 2'b01,
    CCS_ST_RUN  = 2'b11
  } ccs_state_t;

endpackage

/* File: ccs_code_mem.sv */
// Twelve-entry store of 6-bit drive codes, one write port, registered read,
// and every entry also visible in parallel for the current sources.
// Assumes one clock and a caller that never writes and loads at once.
`timescale 1ns/10ps
module ccs_code_mem #(
  parameter int DEPTH = 12,
  parameter int WIDTH = 6,
  parameter int IDX_W = 4
) (
  input  wire logic                   mclk,
  input  wire logic                   we,
  input  wire logic [IDX_W-1:0]       waddr,
  input  wire logic [WIDTH-1:0]       wdata,
  input  wire logic [IDX_W-1:0]       raddr,
  output logic      [WIDTH-1:0]       rdata,
  output logic      [DEPTH*WIDTH-1:0] all_codes
);

  if (DEPTH > (1 << IDX_W)) begin : g_bad_depth
    $error("ccs_code_mem: index too narrow for depth");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata <= mem_reg[raddr];
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_out
      assign all_codes[g*WIDTH +: WIDTH] = mem_reg[g];
    end
  endgenerate

endmodule

/* File: ccs_bank.sv */
// Drive-level register bank for channels d2 to h1 of a 24-channel driver.
// Assumes a same-clock register port (read data one cycle after the read
// strobe) and a nonvolatile store that answers a load index with its code
// on the following cycle.
`timescale 1ns/10ps
module ccs_bank #(
  parameter int NUM_CH = ccs_pkg::CCS_NUM_CH
) (
  input  wire logic                                mclk,
  input  wire logic                                reset,
  input  wire logic [ccs_pkg::CCS_ADDR_W-1:0]      reg_addr,
  input  wire logic [ccs_pkg::CCS_DATA_W-1:0]      reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [ccs_pkg::CCS_DATA_W-1:0]      reg_rdata,
  output logic      [ccs_pkg::CCS_IDX_W-1:0]       nv_index,
  output logic                                     nv_rd,
  input  wire logic [ccs_pkg::CCS_CODE_W-1:0]      nv_code,
  output logic                                     load_busy,
  output logic [NUM_CH*ccs_pkg::CCS_CODE_W-1:0]    drive_codes
);

  localparam int CW = ccs_pkg::CCS_CODE_W;

  if (NUM_CH != ccs_pkg::CCS_NUM_CH) begin : g_bad_num
    $error("ccs_bank: the map holds exactly twelve channels");
  end

  ccs_pkg::ccs_req_t   req;
  ccs_pkg::ccs_state_t state_reg;
  ccs_pkg::ccs_state_t state_next;
  logic [ccs_pkg::CCS_IDX_W-1:0] idx_reg;
  logic [ccs_pkg::CCS_IDX_W-1:0] idx_next;
  logic                          fill_reg;
  logic [ccs_pkg::CCS_IDX_W-1:0] fill_idx_reg;
  logic                          rd_hit_reg;
  logic                          rd_pend_reg;
  logic [CW-1:0]                 mem_rdata;

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  // One offset per channel, in drive_codes order. Each slot is matched on
  // its own, so the hit decode does not lean on the map being contiguous.
  localparam logic [7:0] OFS_TABLE [ccs_pkg::CCS_NUM_CH] = '{
    ccs_pkg::CCS_OFS_D2,
    ccs_pkg::CCS_OFS_E0,
    ccs_pkg::CCS_OFS_E1,
    ccs_pkg::CCS_OFS_E2,
    ccs_pkg::CCS_OFS_F0,
    ccs_pkg::CCS_OFS_F1,
    ccs_pkg::CCS_OFS_F2,
    ccs_pkg::CCS_OFS_G0,
    ccs_pkg::CCS_OFS_G1,
    ccs_pkg::CCS_OFS_G2,
    ccs_pkg::CCS_OFS_H0,
    ccs_pkg::CCS_OFS_H1
  };

  wire [NUM_CH-1:0] ch_sel;

  // The write and read index is the offset minus the first one, which is
  // only right while the slots run on without a gap; elaboration stops if
  // the table ever breaks that.
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_dec
      if (OFS_TABLE[c] != ccs_pkg::CCS_OFS_FIRST + 8'(c)) begin : g_gap
        $error("ccs_bank: drive-level offsets must be consecutive");
      end
      assign ch_sel[c] = (req.addr == OFS_TABLE[c]);
    end
  endgenerate

  wire       addr_hit = |ch_sel;
  wire [7:0] addr_off = req.addr - ccs_pkg::CCS_OFS_FIRST;
  wire [ccs_pkg::CCS_IDX_W-1:0] addr_idx = addr_off[ccs_pkg::CCS_IDX_W-1:0];

  wire run      = (state_reg == ccs_pkg::CCS_ST_RUN);
  wire sw_write = run && req.wr && addr_hit;
  wire [CW-1:0] sw_code =
    req.wdata[ccs_pkg::CCS_CODE_MSB:ccs_pkg::CCS_CODE_LSB];

  // Nonvolatile load walks every channel once after reset; the store's data
  // for index n arrives one cycle after the request and is written then.
  wire last_idx = (idx_reg == ccs_pkg::CCS_IDX_W'(NUM_CH - 1));

  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    case (state_reg)
      ccs_pkg::CCS_ST_IDLE: begin
        state_next = ccs_pkg::CCS_ST_LOAD;
        idx_next   = ccs_pkg::CCS_IDX_RST;
      end
      ccs_pkg::CCS_ST_LOAD: begin
        if (last_idx) begin
          state_next = ccs_pkg::CCS_ST_RUN;
        end else begin
          idx_next = idx_reg + 4'h1;
        end
      end
      ccs_pkg::CCS_ST_RUN: begin
        state_next = ccs_pkg::CCS_ST_RUN;
      end
      default: begin
        state_next = ccs_pkg::CCS_ST_IDLE;
        idx_next   = ccs_pkg::CCS_IDX_RST;
      end
    endcase
  end

  assign nv_rd     = (state_reg == ccs_pkg::CCS_ST_LOAD);
  assign nv_index  = idx_reg;
  assign load_busy = !run || fill_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg    <= ccs_pkg::CCS_ST_IDLE;
      idx_reg      <= ccs_pkg::CCS_IDX_RST;
      fill_reg     <= 1'b0;
      fill_idx_reg <= ccs_pkg::CCS_IDX_RST;
    end else begin
      state_reg    <= state_next;
      idx_reg      <= idx_next;
      fill_reg     <= nv_rd;
      fill_idx_reg <= idx_reg;
    end
  end

  // The last load write lands in the first run cycle; a software write in
  // that same cycle to any channel is dropped, so software wins only
  // once the fill is done.
  wire          mem_we    = fill_reg || (sw_write && !fill_reg);
  wire [3:0]    mem_waddr = fill_reg ? fill_idx_reg : addr_idx;
  wire [CW-1:0] mem_wdata = fill_reg ? nv_code : sw_code;

  ccs_code_mem #(
    .DEPTH (NUM_CH),
    .WIDTH (CW),
    .IDX_W (ccs_pkg::CCS_IDX_W)
  ) u_mem (
    .mclk      (mclk),
    .we        (mem_we),
    .waddr     (mem_waddr),
    .wdata     (mem_wdata),
    .raddr     (addr_idx),
    .rdata     (mem_rdata),
    .all_codes (drive_codes)
  );

  // Read data shows only in the cycle after a mapped read and is zero
  // otherwise, so an unknown word behind an unmapped index never leaks.
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_pend_reg <= 1'b0;
      rd_hit_reg  <= 1'b0;
    end else begin
      rd_pend_reg <= req.rd;
      rd_hit_reg  <= req.rd && addr_hit;
    end
  end

  assign reg_rdata = (rd_pend_reg && rd_hit_reg) ?
                     {ccs_pkg::CCS_RSVD_VAL, mem_rdata} :
                     ccs_pkg::CCS_UNMAP_VAL;

endmodule

/* File: ccs_checker.sv */
// Assertions on the ports of the drive-level bank, bound to ccs_bank.
// Assumes the store answers each index on the following cycle.
`timescale 1ns/10ps
module ccs_checker #(
  parameter int NUM_CH = 12
) (
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic [3:0]        nv_index,
  input wire logic              nv_rd,
  input wire logic [5:0]        nv_code,
  input wire logic              load_busy,
  input wire logic [NUM_CH*6-1:0] drive_codes
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [3:0] widx_reg, lidx1_reg, lidx2_reg;
  logic       lv1_reg, lv2_reg;
  logic [5:0] lcode_reg;
  wire        hit = reg_addr >= 8'h5b && reg_addr <= 8'h66;
  always_ff @(posedge mclk) begin
    widx_reg  <= 4'(reg_addr - 8'h5b);
    lv1_reg   <= nv_rd & ~reset;
    lv2_reg   <= lv1_reg & ~reset;
    lidx1_reg <= nv_index;
    lidx2_reg <= lidx1_reg;
    lcode_reg <= nv_code;
  end
  sequence s_first; nv_rd && nv_index == 4'h0; endsequence
  sequence s_last; nv_rd && nv_index == 4'hb; endsequence
  property p_load; $fell(reset) |-> ##[1:3] s_first ##11 s_last ##1 !nv_rd;
  endproperty
  property p_step;
    nv_rd && $past(nv_rd) |-> nv_index == $past(nv_index) + 4'h1;
  endproperty
  property p_busy; nv_rd |-> load_busy; endproperty
  property p_ready; $fell(nv_rd) |-> ##[0:2] !load_busy; endproperty
  property p_nvload;
    lv2_reg |-> drive_codes[6*lidx2_reg +: 6] == lcode_reg;
  endproperty
  property p_wr; reg_wr && !load_busy && hit |=>
    drive_codes[6*widx_reg +: 6] == $past(reg_wdata[5:0]); endproperty
  property p_rd; reg_rd && !load_busy && hit |=>
    reg_rdata == {2'h0, drive_codes[6*widx_reg +: 6]}; endproperty
  property p_unmap; reg_rd && !hit |=> reg_rdata == 8'h00; endproperty
  property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_rsvd; reg_rdata[7:6] == 2'h0; endproperty
  a_load: assert property (p_load) else $error("load sequence wrong");
  a_step: assert property (p_step) else $error("load index skipped");
  a_busy: assert property (p_busy) else $error("busy low in load");
  a_ready: assert property (p_ready) else $error("busy stuck");
  a_nvload: assert property (p_nvload) else $error("bad load");
  a_wr: assert property (p_wr) else $error("write lost");
  a_rd: assert property (p_rd) else $error("read wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped hit");
  a_idle: assert property (p_idle) else $error("stray read data");
  a_rsvd: assert property (p_rsvd) else $error("upper bits set");
endmodule
bind ccs_bank ccs_checker #(.NUM_CH(NUM_CH)) i_ccs_checker (.mclk, .reset,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nv_index, .nv_rd,
  .nv_code, .load_busy, .drive_codes);

/* File: ccs_bank_tb.sv */
// Self-checking bench for the drive-level bank.
// Assumes the package, the bank and the bound checker compile first.
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module ccs_bank_tb;
  logic        mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, pend = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, d, v;
  logic [5:0]  nv_code = 0, mirror [12];
  logic [3:0]  nv_index;
  logic        nv_rd, load_busy;
  logic [71:0] drive_codes;
  logic [7:0]  expq [$];
  int          err_count = 0, cmp_count = 0;
  ccs_bank i_ccs_bank (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .nv_index, .nv_rd, .nv_code, .load_busy,
    .drive_codes);
  initial forever #4 mclk = ~mclk;
  // The store answers the index of the previous cycle with a known code.
  always @(posedge mclk) nv_code <= 6'h2a ^ {2'h0, nv_index};
  always @(posedge mclk) begin
    if (pend) begin
      d = expq.pop_front();
      `CHK("reg_rdata", d, reg_rdata)
    end
    pend <= reg_rd;
  end
  task automatic bus(input bit w, input logic [7:0] a, x, e);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= x;
    if (!w) expq.push_back(e);
    @(posedge mclk);
  endtask
  task automatic idle();
    reg_wr <= 0;
    reg_rd <= 0;
    @(posedge mclk);
  endtask
  // Waits for the edge's updates to land before sampling the codes.
  task automatic chk_all();
    #1;
    for (int i = 0; i < 12; i++)
      `CHK("drive_codes", mirror[i], drive_codes[6*i +: 6])
    @(posedge mclk);
  endtask
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hc10c_ad56));
    repeat (6) @(posedge mclk);
    reset <= 0;
    repeat (6) @(posedge mclk);
    bus(1, 8'h5b, 8'h3f, 0);
    idle();
    repeat (30) @(posedge mclk);
    `CHK("load_busy", 1'b0, load_busy)
    for (int i = 0; i < 12; i++) mirror[i] = 6'h2a ^ 6'(i);
    chk_all();
    for (int i = 0; i < 12; i++)
      bus(0, 8'h5b + 8'(i), 0, {2'h0, mirror[i]});
    for (int i = 0; i < 12; i++) begin
      v = 8'($urandom) | 8'hc0;
      mirror[i] = v[5:0];
      bus(1, 8'h5b + 8'(i), v, 0);
      bus(0, 8'h5b + 8'(i), 0, {2'h0, v[5:0]});
    end
    bus(1, 8'h5a, 8'hff, 0);
    bus(1, 8'h67, 8'hff, 0);
    bus(0, 8'h5a, 0, 8'h00);
    bus(0, 8'h67, 0, 8'h00);
    idle();
    chk_all();
    repeat (3) @(posedge mclk);
    // A second reset must reload every code over what software wrote.
    reset <= 1;
    repeat (2) @(posedge mclk);
    reset <= 0;
    repeat (4) @(posedge mclk);
    `CHK("load_busy", 1'b1, load_busy)
    repeat (16) @(posedge mclk);
    `CHK("load_busy", 1'b0, load_busy)
    for (int i = 0; i < 12; i++) mirror[i] = 6'h2a ^ 6'(i);
    chk_all();
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge mclk);
    err_count++;
    wrap_up();
  end
endmodule
